// [hw/ccs_pkg.sv]
package ccs_pkg;

    // control register map
    localparam logic [7:0] CCS_REG_CTRL = 8'h0f;
    localparam int CCS_BIT_EXT_CLAMP = 7;
    localparam int CCS_BIT_CLAMP_SENSE = 6;
    localparam int CCS_BIT_COAST_SENSE = 3;

    // values after reset
    localparam logic CCS_RST_EXT_CLAMP = 1'b0;
    localparam logic CCS_RST_CLAMP_SENSE = 1'b0;
    localparam logic CCS_RST_COAST_SENSE = 1'b1;

    // embedded sync slicing threshold, in millivolts
    localparam int CCS_SOG_STEP_MV = 10;
    localparam int CCS_SOG_MIN_MV = 10;
    localparam int CCS_SOG_MAX_MV = 330;
    localparam int CCS_SOG_DEF_MV = 150;
    localparam int CCS_SOG_W = 6;
    localparam logic [CCS_SOG_W-1:0] CCS_SOG_MIN_CODE =
        CCS_SOG_W'(CCS_SOG_MIN_MV / CCS_SOG_STEP_MV);
    localparam logic [CCS_SOG_W-1:0] CCS_SOG_MAX_CODE =
        CCS_SOG_W'(CCS_SOG_MAX_MV / CCS_SOG_STEP_MV);
    localparam logic [CCS_SOG_W-1:0] CCS_SOG_DEF_CODE =
        CCS_SOG_W'(CCS_SOG_DEF_MV / CCS_SOG_STEP_MV);

    // internal clamp window counters, in pixel clock periods
    localparam int CCS_CNT_W = 8;
    localparam int CCS_SYNC_STAGES = 2;

    typedef struct packed {
        logic ext_clamp;
        logic clamp_sense;
        logic coast_sense;
    } ccs_ctrl_s;

    typedef struct packed {
        logic line_sync;
        logic coast;
        logic clamp;
        logic embedded_sync;
    } ccs_pins_s;

    typedef enum logic [2:0] {
        CCS_ST_IDLE = 3'b001,
        CCS_ST_DELAY = 3'b010,
        CCS_ST_ACTIVE = 3'b100
    } ccs_clamp_e;

endpackage

// [hw/ccs_sync2.sv]
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser for pins arriving from outside core_clk
module ccs_sync2 #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            meta <= '0;
            dout <= '0;
        end else if (ce) begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule

`default_nettype wire

// [hw/ccs_control.sv]
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// (R1) External clamp timing is used only when control bit 7 is 1; it resets to 0.
// (R2) With external clamp off the clamp pin is ignored and the window is timed internally from the line sync trailing edge.
// (R3) Clamp pin active level follows the clamp sense bit, control bit 6.
// (R4) The source asserts the clamp pin only while reference black is present.
// (R5) Unused clamp pin is tied low with the external clamp bit left at 0.
// (R6) While coast is active the clock generator stops tracking line sync and holds frequency and phase.
// (R7) Coast pin active level follows the coast sense bit, control bit 3.
// (R8) The coast sense bit is 1 after reset.
// (R9) Unused coast pin is held so that coast is never active.
// (R10) The slicing threshold is 10 mV to 330 mV in 10 mV steps, 150 mV by default.
// (R11) The comparator result goes to the embedded sync output uninverted.
// (R12) Only the leading edge of line sync is active, falling for sense 0, rising for sense 1.
// (R13) Internal clamp delay and width count pixel clocks from programmed values on every line.
module ccs_control #(
    parameter int CNT_W = ccs_pkg::CCS_CNT_W
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    output logic [7:0] reg_rdata,
    input wire ccs_pkg::ccs_pins_s pins,
    input wire logic line_sync_sense,
    input wire logic [CNT_W-1:0] clamp_delay,
    input wire logic [CNT_W-1:0] clamp_width,
    input wire logic [ccs_pkg::CCS_SOG_W-1:0] sog_level,
    output logic clamp_active,
    output logic coast_active,
    output logic pll_track,
    output logic pll_phase_ref,
    output logic embedded_sync_output,
    output logic [ccs_pkg::CCS_SOG_W-1:0] sog_threshold_code
);
    import ccs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation

    ccs_pins_s pins_s;
    ccs_ctrl_s ctrl;
    ccs_clamp_e state;
    ccs_clamp_e next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic norm_q;
    logic norm_now;
    logic lead;
    logic trail;
    logic coast_now;
    logic ext_now;
    logic [1:0] settle;
    logic edges_ok;

    ccs_sync2 #(
        .W($bits(ccs_pins_s))
    ) u_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .ce(ce),
        .din(pins),
        .dout(pins_s)
    );

    function automatic logic level_active(input logic pin, input logic sense);
        level_active = (pin == sense);
    endfunction

    function automatic logic [CCS_SOG_W-1:0] sat_code(
        input logic [CCS_SOG_W-1:0] code
    );
        if (code < CCS_SOG_MIN_CODE) begin
            sat_code = CCS_SOG_MIN_CODE;
        end else if (code > CCS_SOG_MAX_CODE) begin
            sat_code = CCS_SOG_MAX_CODE;
        end else begin
            sat_code = code;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // control register

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ctrl.ext_clamp <= CCS_RST_EXT_CLAMP; // R1
            ctrl.clamp_sense <= CCS_RST_CLAMP_SENSE;
            ctrl.coast_sense <= CCS_RST_COAST_SENSE; // R8
        end else if (ce && reg_wr && reg_addr == CCS_REG_CTRL) begin
            ctrl.ext_clamp <= reg_wdata[CCS_BIT_EXT_CLAMP]; // R1
            ctrl.clamp_sense <= reg_wdata[CCS_BIT_CLAMP_SENSE]; // R3
            ctrl.coast_sense <= reg_wdata[CCS_BIT_COAST_SENSE]; // R7
        end
    end

    // reserved bits and other addresses read as zero
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (ce) begin
            reg_rdata <= 8'h00;
            if (reg_addr == CCS_REG_CTRL) begin
                reg_rdata[CCS_BIT_EXT_CLAMP] <= ctrl.ext_clamp;
                reg_rdata[CCS_BIT_CLAMP_SENSE] <= ctrl.clamp_sense;
                reg_rdata[CCS_BIT_COAST_SENSE] <= ctrl.coast_sense;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // line sync edges and coast

    // normalise so that high means sync asserted
    assign norm_now = line_sync_sense ? pins_s.line_sync : ~pins_s.line_sync;
    // synchroniser holds reset zeros, not the pin, so no edges until filled
    assign edges_ok = (settle == 2'(CCS_SYNC_STAGES + 1));
    assign lead = edges_ok & norm_now & ~norm_q; // R12
    assign trail = edges_ok & ~norm_now & norm_q;
    assign coast_now = level_active(pins_s.coast, ctrl.coast_sense); // R7
    assign ext_now = level_active(pins_s.clamp, ctrl.clamp_sense); // R3

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            norm_q <= 1'b0;
            settle <= 2'h0;
        end else if (ce) begin
            norm_q <= norm_now;
            if (!edges_ok) begin
                settle <= settle + 2'h1;
            end
        end
    end

    // phase reference withheld in coast so the generator free-runs
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            coast_active <= 1'b0;
            pll_track <= 1'b1;
            pll_phase_ref <= 1'b0;
        end else if (ce) begin
            coast_active <= coast_now; // R6
            pll_track <= ~coast_now; // R6
            pll_phase_ref <= lead & ~coast_now; // R12
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // internal clamp window

    // a new trailing edge restarts the window, so a short line never skips
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        if (trail) begin
            next_state = CCS_ST_DELAY; // R13
            next_cnt = clamp_delay;
        end else begin
            case (state)
                CCS_ST_IDLE: begin
                    next_state = CCS_ST_IDLE;
                end
                CCS_ST_DELAY: begin
                    if (cnt != '0) begin
                        next_cnt = cnt - 1'b1;
                    end else if (clamp_width != '0) begin
                        next_state = CCS_ST_ACTIVE; // R13
                        next_cnt = clamp_width - 1'b1;
                    end else begin
                        next_state = CCS_ST_IDLE;
                    end
                end
                CCS_ST_ACTIVE: begin
                    if (cnt != '0) begin
                        next_cnt = cnt - 1'b1;
                    end else begin
                        next_state = CCS_ST_IDLE;
                    end
                end
                default: begin
                    next_state = CCS_ST_IDLE;
                    next_cnt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state <= CCS_ST_IDLE;
            cnt <= '0;
        end else if (ce) begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // timer keeps running in external mode so switching back is seamless
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            clamp_active <= 1'b0;
        end else if (ce) begin
            if (ctrl.ext_clamp) begin
                clamp_active <= ext_now; // R1 R3
            end else begin
                clamp_active <= (next_state == CCS_ST_ACTIVE); // R2
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // embedded sync slicer

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            embedded_sync_output <= 1'b0;
            sog_threshold_code <= CCS_SOG_DEF_CODE; // R10
        end else if (ce) begin
            embedded_sync_output <= pins_s.embedded_sync; // R11
            sog_threshold_code <= sat_code(sog_level); // R10
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    ext_clamp_path_a: assert property ( // R1
        @(posedge core_clk) disable iff (!rstn)
        ce && ctrl.ext_clamp |=> clamp_active == $past(ext_now))
        else $error("external clamp not followed");

    clamp_sense_level_a: assert property ( // R3
        @(posedge core_clk) disable iff (!rstn)
        ce && ctrl.ext_clamp && pins_s.clamp == ctrl.clamp_sense
        |=> clamp_active)
        else $error("clamp sense not honoured");

    int_clamp_start_a: assert property ( // R2
        @(posedge core_clk) disable iff (!rstn)
        ce && !ctrl.ext_clamp && !$past(ctrl.ext_clamp)
        && !$past(ctrl.ext_clamp, 2) && $rose(clamp_active)
        |-> $past(state) == CCS_ST_DELAY && $past(cnt) == '0)
        else $error("internal clamp began off schedule");

    int_clamp_time_a: assert property ( // R13
        @(posedge core_clk) disable iff (!rstn)
        ce && !ctrl.ext_clamp && trail && clamp_delay == '0
        && clamp_width != '0 ##1 ce && !trail && !ctrl.ext_clamp
        && clamp_width != '0
        |=> clamp_active)
        else $error("clamp window late after trailing edge");

    coast_hold_a: assert property ( // R6
        @(posedge core_clk) disable iff (!rstn)
        ce && coast_now |=> !pll_phase_ref && !pll_track)
        else $error("tracking during coast");

    coast_sense_a: assert property ( // R7
        @(posedge core_clk) disable iff (!rstn)
        ce |=> coast_active == $past(pins_s.coast == ctrl.coast_sense))
        else $error("coast sense wrong");

    coast_reset_a: assert property ( // R8
        @(posedge core_clk)
        !rstn |=> ctrl.coast_sense && !ctrl.ext_clamp)
        else $error("reset values wrong");

    sog_range_a: assert property ( // R10
        @(posedge core_clk) disable iff (!rstn)
        sog_threshold_code >= CCS_SOG_MIN_CODE
        && sog_threshold_code <= CCS_SOG_MAX_CODE)
        else $error("threshold out of range");

    sog_pass_a: assert property ( // R11
        @(posedge core_clk) disable iff (!rstn)
        ce |=> embedded_sync_output == $past(pins_s.embedded_sync))
        else $error("embedded sync inverted or late");

    lead_edge_a: assert property ( // R12
        @(posedge core_clk) disable iff (!rstn)
        ce && edges_ok && !coast_now && norm_now && !norm_q |=> pll_phase_ref)
        else $error("leading edge missed");

endmodule

`default_nettype wire

// [bench/ccs_src.sv]
`timescale 1ns/1ps
`default_nettype none

module ccs_src (
    input wire logic core_clk,
    output ccs_pkg::ccs_pins_s pins
);
    import ccs_pkg::*;

    // idle: sync high, unused clamp low, coast low for sense 1
    initial pins = '{1'b1, 1'b0, 1'b0, 1'b0};

    task automatic set_line(input logic v);
        pins.line_sync = v;
    endtask

    task automatic set_coast(input logic v);
        pins.coast = v;
    endtask

    task automatic set_sog(input logic v);
        pins.embedded_sync = v;
    endtask

    // clamp only for n clocks of back porch, then released
    task automatic porch_clamp(input logic act, input int n);
        pins.clamp = act;
        repeat (n) @(negedge core_clk);
        pins.clamp = ~act;
    endtask
endmodule

`default_nettype wire

// [bench/tb_clamp_coast_sync_control.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_clamp_coast_sync_control;
    import ccs_pkg::*;

    logic core_clk = 1'b0;
    logic rstn;
    logic ce;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic line_sync_sense;
    logic [7:0] clamp_delay;
    logic [7:0] clamp_width;
    logic [5:0] sog_level;
    logic [7:0] reg_rdata;
    ccs_pins_s pins;
    logic clamp_active, coast_active, pll_track, pll_phase_ref;
    logic embedded_sync_output;
    logic [5:0] sog_threshold_code;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    logic [7:0] v;

    always #25 core_clk = ~core_clk;

    ccs_src u_src (.core_clk(core_clk), .pins(pins));

    ccs_control u_dut (
        .core_clk(core_clk), .rstn(rstn), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rdata(reg_rdata), .pins(pins),
        .line_sync_sense(line_sync_sense), .clamp_delay(clamp_delay),
        .clamp_width(clamp_width), .sog_level(sog_level),
        .clamp_active(clamp_active), .coast_active(coast_active),
        .pll_track(pll_track), .pll_phase_ref(pll_phase_ref),
        .embedded_sync_output(embedded_sync_output),
        .sog_threshold_code(sog_threshold_code)
    );

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // hang guard, about twenty times the expected run length
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            test_done();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
        // idle edge so a following write raises the strobe cleanly
        cyc(1);
    endtask

    // read data registered one edge after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        cyc(1);
        d = reg_rdata;
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(CCS_REG_CTRL, v);
        check(v, 8'h08);
        check(8'(sog_threshold_code), 8'(CCS_SOG_DEF_CODE));
        check(8'(pll_track), 8'h01);
        wr(CCS_REG_CTRL, 8'hff);
        wr(8'h10, 8'h00);
        rd(CCS_REG_CTRL, v);
        check(v, 8'hc8);
        rd(8'h10, v);
        check(v, 8'h00);
        wr(CCS_REG_CTRL, 8'h08);
        $display("registers done");
    endtask

    task automatic t_sog();
        logic [5:0] code [6] = '{6'h00, 6'h01, 6'h0f, 6'h21, 6'h22, 6'h3f};
        logic [5:0] exp [6] = '{6'h01, 6'h01, 6'h0f, 6'h21, 6'h21, 6'h21};
        for (int i = 0; i < 6; i++) begin
            sog_level = code[i];
            cyc(2);
            check(8'(sog_threshold_code), 8'(exp[i]));
        end
        sog_level = 6'h0f;
        u_src.set_sog(1'b1);
        cyc(2);
        check(8'(embedded_sync_output), 8'h00);
        cyc(1);
        check(8'(embedded_sync_output), 8'h01);
        u_src.set_sog(1'b0);
        cyc(3);
        check(8'(embedded_sync_output), 8'h00);
        $display("threshold done");
    endtask

    // clamp pin sits at 0, active for sense 0, and must be ignored
    task automatic t_internal(input int d, input int w);
        clamp_delay = 8'(d);
        clamp_width = 8'(w);
        u_src.set_line(1'b0);
        cyc(4);
        u_src.set_line(1'b1);
        for (int n = 1; n <= d + w + 4; n++) begin
            cyc(1);
            check(8'(clamp_active), 8'(n >= 4 + d && n < 4 + d + w));
        end
        $display("internal clamp done");
    endtask

    task automatic t_external();
        wr(CCS_REG_CTRL, 8'h88);
        cyc(3);
        check(8'(clamp_active), 8'h01);
        wr(CCS_REG_CTRL, 8'hc8);
        cyc(3);
        check(8'(clamp_active), 8'h00);
        u_src.porch_clamp(1'b1, 4);
        check(8'(clamp_active), 8'h01);
        cyc(3);
        check(8'(clamp_active), 8'h00);
        wr(CCS_REG_CTRL, 8'h08);
        $display("external clamp done");
    endtask

    task automatic t_coast();
        u_src.set_coast(1'b1);
        cyc(2);
        check(8'(coast_active), 8'h00);
        cyc(1);
        check(8'({coast_active, pll_track}), 8'h02);
        u_src.set_line(1'b0);
        for (int n = 0; n < 5; n++) begin
            cyc(1);
            check(8'(pll_phase_ref), 8'h00);
        end
        u_src.set_line(1'b1);
        u_src.set_coast(1'b0);
        cyc(3);
        check(8'({coast_active, pll_track}), 8'h01);
        wr(CCS_REG_CTRL, 8'h00);
        cyc(3);
        check(8'(coast_active), 8'h01);
        u_src.set_coast(1'b1);
        cyc(3);
        check(8'(coast_active), 8'h00);
        wr(CCS_REG_CTRL, 8'h08);
        u_src.set_coast(1'b0);
        cyc(4);
        $display("coast done");
    endtask

    task automatic t_lead(input logic s);
        line_sync_sense = s;
        u_src.set_line(~s);
        cyc(4);
        u_src.set_line(s);
        cyc(2);
        check(8'(pll_phase_ref), 8'h00);
        cyc(1);
        check(8'(pll_phase_ref), 8'h01);
        cyc(1);
        check(8'(pll_phase_ref), 8'h00);
        u_src.set_line(~s);
        for (int n = 0; n < 4; n++) begin
            cyc(1);
            check(8'(pll_phase_ref), 8'h00);
        end
        $display("leading edge done");
    endtask

    // mid-run reset: control byte restored, no false sync edge on release
    task automatic t_reset();
        wr(CCS_REG_CTRL, 8'hc0);
        rstn = 1'b0;
        line_sync_sense = 1'b0;
        cyc(2);
        rstn = 1'b1;
        rd(CCS_REG_CTRL, v);
        check(v, 8'h08);
        for (int n = 0; n < 8; n++) begin
            check(8'(pll_phase_ref), 8'h00);
            check(8'(clamp_active), 8'h00);
            cyc(1);
        end
        $display("reset done");
    endtask

    // enable low freezes everything, a register write included
    task automatic t_freeze();
        ce = 1'b0;
        u_src.set_sog(1'b1);
        wr(CCS_REG_CTRL, 8'hc0);
        cyc(2);
        check(8'(embedded_sync_output), 8'h00);
        ce = 1'b1;
        rd(CCS_REG_CTRL, v);
        check(v, 8'h08);
        cyc(2);
        check(8'(embedded_sync_output), 8'h01);
        u_src.set_sog(1'b0);
        $display("enable done");
    endtask

    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        reg_addr = CCS_REG_CTRL;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        line_sync_sense = 1'b0;
        clamp_delay = 8'h00;
        clamp_width = 8'h00;
        sog_level = 6'h00;
        cyc(3);
        // level input is off default, so only reset can give this code
        check(8'(sog_threshold_code), 8'(CCS_SOG_DEF_CODE));
        sog_level = 6'h0f;
        rstn = 1'b1;
        t_regs();
        t_sog();
        t_internal(0, 2);
        t_internal(2, 3);
        t_external();
        t_coast();
        t_lead(1'b0);
        t_lead(1'b1);
        t_reset();
        t_freeze();
        test_done();
    end
endmodule

`default_nettype wire
